// ### include/smc_pkg.sv
// shared constants and types of the static memory controller
package smc_pkg;

  // --------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------
  localparam logic [31:0] SMC_REG_BASE = 32'hffffec00; // register window base
  localparam logic [3:0] SMC_OFS_CFG_A = 4'h0; // banks 0 and 1
  localparam logic [3:0] SMC_OFS_CFG_B = 4'h4; // banks 2 and 3
  localparam logic [3:0] SMC_OFS_CFG_C = 4'h8; // banks 4 and 5
  localparam logic [3:0] SMC_OFS_CFG_D = 4'hc; // banks 6 and 7
  localparam logic [31:0] SMC_CFG_A_RST = 32'h00000004; // first reg reset
  localparam logic [31:0] SMC_CFG_RST = 32'h00000000; // other regs reset
  localparam int SMC_REG_IDX_LSB = 2; // word index inside the window

  // --------------------------------------------------------------------
  // 16-bit bank field layout
  // --------------------------------------------------------------------
  localparam int SMC_FLD_W = 16; // width of one bank field
  localparam int SMC_F_NWAIT_LSB = 0; // standard wait count, 4 bits
  localparam int SMC_F_SWAIT_LSB = 4; // sequential wait count, 3 bits
  localparam int SMC_F_BURST_EN = 7; // burst read enable
  localparam int SMC_F_WIDTH_LSB = 8; // bank width, 2 bits
  localparam int SMC_F_CLK_EN = 10; // expansion clock enable
  localparam int SMC_F_FLASH = 11; // flash timing enable
  localparam int SMC_F_BUS_STYLE = 12; // alternate bus style
  localparam int SMC_F_RDY_POL = 13; // ready polarity select
  localparam int SMC_F_SEL_LOW = 14; // high banks select active low
  localparam int SMC_F_PANEL_EN = 15; // bank 7 panel direct access
  localparam int SMC_F_PANEL_LSB = 0; // bank 7 panel wait, 6 bits

  // --------------------------------------------------------------------
  // encodings
  // --------------------------------------------------------------------
  localparam logic [1:0] SMC_W32 = 2'h0; // 32-bit bank
  localparam logic [1:0] SMC_W16 = 2'h1; // 16-bit bank
  localparam logic [1:0] SMC_W8 = 2'h2; // 8-bit bank
  localparam logic [1:0] SMC_BOOT_32 = 2'h0; // strap code for 32-bit
  localparam logic [1:0] SMC_BOOT_16 = 2'h2; // strap code for 16-bit
  localparam logic [1:0] SMC_BOOT_8 = 2'h1; // strap code for 8-bit
  localparam logic [1:0] SMC_BSIZE_BYTE = 2'h0; // byte transfer
  localparam logic [1:0] SMC_BSIZE_HALF = 2'h1; // halfword transfer
  localparam logic [1:0] SMC_BSIZE_WORD = 2'h2; // word transfer
  localparam logic [1:0] SMC_BTRAN_IDLE = 2'h0; // address-only cycle
  localparam logic [1:0] SMC_BTRAN_SEQ = 2'h3; // sequential transfer
  localparam int SMC_BANK_LSB = 24; // bank code lsb in the address
  localparam logic [2:0] SMC_BANK_PANEL = 3'h7; // bank with panel mode
  localparam int SMC_ADDR_W = 24; // external address width

  // controller states
  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_RECOVER} smc_state_t;

endpackage : smc_pkg

// ### verilog/smc_sync2.sv
// two-flop synchroniser for levels entering the bus clock domain
`timescale 1ns/100ps
`default_nettype none
module smc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  // first stage is read only by the second stage
  logic [WIDTH-1:0] meta;

  // ----------------------------------------------------------------------
  // two stages, cleared by the synchronous reset
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule : smc_sync2
`default_nettype wire

// ### verilog/smc_top.sv
// static memory controller: bank decode, wait states and lane sequencing
//
// What this block does
// - bank code selects one of eight selects
// - expansion clock follows bus clock when enabled
// - narrow banks take several stalled sub-transfers
// - standard waits equal count plus one
// - sequential burst waits equal the burst count
// - ready extends access until it goes inactive
// - ready polarity chosen per bank
// - burst timing for three reads after quad
// - burst timing only with burst enable set
// - byte strobes decoded from size and address
// - four config registers, first resets to four
// - low half even bank, high half odd
// - fixed bit layout inside each bank field
// - width codes 32, 16, 8 bits
// - high bank selects may be active low
// - bank 7 panel mode uses panel waits
// - flash timing delays strobe and enable
// - bus style gives direction plus data strobes
// - back-to-back accesses keep expansion clock running
// - boot straps set bank zero width
// - output enable low through external reads
`timescale 1ns/100ps
`default_nettype none
module smc_top (
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic I_CLK_LINK,
  input wire logic I_MEM_SELECT,
  input wire logic I_CONFIG_REG_SELECT,
  input wire logic [31:0] I_BA,
  input wire logic [1:0] I_BTRAN,
  input wire logic [1:0] I_BSIZE,
  input wire logic I_BWRITE,
  input wire logic [31:0] I_BD,
  output logic [31:0] O_BD,
  output logic O_BD_OE,
  output logic O_BWAIT,
  input wire logic I_EXTERNAL_READY_IN,
  input wire logic [1:0] I_BOOT_MODE,
  input wire logic [31:0] I_EXT_DATA,
  output logic [31:0] O_EXT_DATA,
  output logic O_EXT_DATA_OE,
  output logic [23:0] O_EXT_ADDR,
  output logic [5:0] O_BANK_SELECT_LOW,
  output logic [1:0] O_BANK_SELECT_HIGH,
  output logic [3:0] O_BYTE_WRITE_STROBE,
  output logic O_READ_OUTPUT_ENABLE_N,
  output logic O_READ_NOT_WRITE,
  output logic [1:0] O_LANE_SEQUENCE_CTRL,
  output logic O_EXPANSION_CLOCK_OUT
);

  // ----------------------------------------------------------------------
  // pin inputs and the link-side ready capture
  // ----------------------------------------------------------------------
  logic rdy_link; // ready caught on the link clock falling edge
  logic rdy_sync; // ready in the bus clock domain
  logic [1:0] boot_sync; // boot straps after two flops
  logic [31:0] ext_sync; // external read data after two flops

  // sampling on the falling edge gives the peripheral half a cycle
  always_ff @(negedge I_CLK_LINK)
  begin
    rdy_link <= I_EXTERNAL_READY_IN;
  end

  smc_sync2 #(.WIDTH(1)) u_sync_rdy (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_async(rdy_link),
    .o_sync(rdy_sync)
  );

  smc_sync2 #(.WIDTH(2)) u_sync_boot (
    .i_clk(I_CLK_SYS),
    .i_rst(1'b0),
    .i_async(I_BOOT_MODE),
    .o_sync(boot_sync)
  );

  smc_sync2 #(.WIDTH(32)) u_sync_data (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_async(I_EXT_DATA),
    .o_sync(ext_sync)
  );

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  logic [31:0] cfg [4]; // four bank pair registers
  logic [1:0] reg_idx; // addressed register
  logic reg_wr; // register write this cycle
  logic reg_rd; // register read this cycle
  logic [1:0] boot_width; // bank zero width from the straps

  assign reg_idx = I_BA[smc_pkg::SMC_REG_IDX_LSB +: 2];
  assign reg_wr = I_CONFIG_REG_SELECT && I_BWRITE;
  assign reg_rd = I_CONFIG_REG_SELECT && !I_BWRITE;

  // strap decode, unknown code falls back to the widest bank
  assign boot_width = (boot_sync == smc_pkg::SMC_BOOT_16) ? smc_pkg::SMC_W16 :
                      (boot_sync == smc_pkg::SMC_BOOT_8) ? smc_pkg::SMC_W8 :
                      smc_pkg::SMC_W32;

  // register file; bank zero width is refreshed from the straps while
  // reset is held, so reset must last at least three clock edges
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
    begin
      cfg[0] <= smc_pkg::SMC_CFG_A_RST;
      cfg[0][smc_pkg::SMC_F_WIDTH_LSB +: 2] <= boot_width;
      cfg[1] <= smc_pkg::SMC_CFG_RST;
      cfg[2] <= smc_pkg::SMC_CFG_RST;
      cfg[3] <= smc_pkg::SMC_CFG_RST;
    end
    else if (reg_wr)
    begin
      cfg[reg_idx] <= I_BD;
    end
  end

  // ----------------------------------------------------------------------
  // transfer latched at request time
  // ----------------------------------------------------------------------
  smc_pkg::smc_state_t state; // controller state
  smc_pkg::smc_state_t next_state; // state for the next edge
  logic [31:0] held_addr; // latched bus address
  logic [1:0] held_size; // latched transfer size
  logic held_wr; // latched direction
  logic seq_req; // latched sequential flag
  logic [31:0] held_wdata; // latched write data
  logic [31:0] rdata; // read word being assembled
  logic [1:0] sub; // current sub-transfer index
  logic [6:0] cnt; // cycle count inside a sub-transfer
  logic linger; // expansion clock kept one cycle after a transfer

  logic take; // memory request accepted this edge
  assign take = (state == smc_pkg::ST_IDLE) && I_MEM_SELECT &&
                (I_BTRAN != smc_pkg::SMC_BTRAN_IDLE);

  // the taking edge decodes the request itself, else pins lag a transfer
  logic [31:0] addr, wdata; // current transfer
  logic [1:0] size; // current size
  logic wr; // current direction
  assign addr = take ? I_BA : held_addr;
  assign size = take ? I_BSIZE : held_size;
  assign wr = take ? I_BWRITE : held_wr;
  assign wdata = take ? I_BD : held_wdata;

  // ----------------------------------------------------------------------
  // bank field of the addressed bank
  // ----------------------------------------------------------------------
  logic [2:0] bank; // bank code of the transfer
  logic [15:0] fld; // 16-bit field of that bank
  logic [1:0] bwidth; // bank width code
  logic [1:0] lw; // log2 of bank width in bytes
  logic panel; // panel direct access active

  assign bank = addr[smc_pkg::SMC_BANK_LSB +: 3];
  // bit 0 of the bank picks the half, the rest picks the register
  assign fld = cfg[bank[2:1]][bank[0]*smc_pkg::SMC_FLD_W +:
                              smc_pkg::SMC_FLD_W];
  assign bwidth = fld[smc_pkg::SMC_F_WIDTH_LSB +: 2];
  // reserved width code is run as a 32-bit bank
  assign lw = (bwidth == smc_pkg::SMC_W16) ? 2'h1 :
              (bwidth == smc_pkg::SMC_W8) ? 2'h0 : 2'h2;
  assign panel = (bank == smc_pkg::SMC_BANK_PANEL) &&
                 fld[smc_pkg::SMC_F_PANEL_EN];

  // ----------------------------------------------------------------------
  // sub-transfer sequencing
  // ----------------------------------------------------------------------
  logic [1:0] nsub_m1; // sub-transfers minus one
  logic [1:0] base_lo; // size-aligned low address bits
  logic [1:0] sub_lo; // low address bits of this sub-transfer
  logic [1:0] unit_lo; // low bits of the bank-wide unit index
  logic quad; // unit sits on a quad boundary
  logic use_burst; // shorter sequential timing applies
  logic [6:0] waits; // wait states of this sub-transfer
  logic last_cyc; // final cycle of this sub-transfer
  logic hold; // external party stretches the access
  logic last_sub; // this sub-transfer ends the bus transfer

  assign nsub_m1 = (size > lw) ?
                   2'((3'h1 << (size - lw)) - 3'h1) : 2'h0;
  assign base_lo = (size == smc_pkg::SMC_BSIZE_WORD) ? 2'h0 :
                   (size == smc_pkg::SMC_BSIZE_HALF) ?
                   {addr[1], 1'b0} : addr[1:0];
  assign sub_lo = 2'(base_lo + (sub << lw));
  assign unit_lo = (lw == 2'h2) ? addr[3:2] :
                   (lw == 2'h1) ? {addr[2], sub_lo[1]} : sub_lo;
  assign quad = (unit_lo == 2'h0);
  assign use_burst = !wr && fld[smc_pkg::SMC_F_BURST_EN] && !quad &&
                     (seq_req || (sub != 2'h0));
  assign waits = panel ?
                 7'({1'b0, fld[smc_pkg::SMC_F_PANEL_LSB +: 6]} + 7'h1) :
                 use_burst ? 7'(fld[smc_pkg::SMC_F_SWAIT_LSB +: 3]) :
                 7'(fld[smc_pkg::SMC_F_NWAIT_LSB +: 4]) + 7'h1;
  assign last_cyc = (cnt == waits);
  assign hold = fld[smc_pkg::SMC_F_RDY_POL] ? rdy_sync : !rdy_sync;
  assign last_sub = (sub == nsub_m1);

  // ----------------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------------
  logic sub_done; // sub-transfer finishes on this edge
  assign sub_done = (state == smc_pkg::ST_ACCESS) && last_cyc && !hold;

  always_comb
  begin
    next_state = state;
    case (state)
      smc_pkg::ST_IDLE:
      begin
        if (take)
          next_state = smc_pkg::ST_ACCESS;
      end
      smc_pkg::ST_ACCESS:
      begin
        // narrow banks run their sub-transfers back to back
        if (sub_done && last_sub)
          next_state = smc_pkg::ST_RECOVER;
      end
      smc_pkg::ST_RECOVER:
      begin
        // one dead cycle holds the address after strobes and selects go inactive
        next_state = smc_pkg::ST_IDLE;
      end
      default:
      begin
        next_state = smc_pkg::ST_IDLE;
      end
    endcase
  end

  // state, counters and the latched request
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
    begin
      state <= smc_pkg::ST_IDLE;
      cnt <= 7'h0;
      sub <= 2'h0;
      held_addr <= 32'h0;
      held_size <= 2'h0;
      held_wr <= 1'b0;
      seq_req <= 1'b0;
      held_wdata <= 32'h0;
    end
    else
    begin
      state <= next_state;
      if (take)
      begin
        held_addr <= I_BA;
        held_size <= I_BSIZE;
        held_wr <= I_BWRITE;
        seq_req <= (I_BTRAN == smc_pkg::SMC_BTRAN_SEQ);
        held_wdata <= I_BD;
        cnt <= 7'h0;
        sub <= 2'h0;
      end
      else if (sub_done)
      begin
        cnt <= 7'h0;
        sub <= last_sub ? 2'h0 : 2'(sub + 2'h1);
      end
      else if (state == smc_pkg::ST_ACCESS && !last_cyc)
      begin
        cnt <= 7'(cnt + 7'h1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // read assembly: each narrow part lands at its own lane of the word
  // ----------------------------------------------------------------------
  logic [31:0] next_rdata; // read word after this edge
  always_comb
  begin
    next_rdata = rdata;
    if (sub_done && !wr)
    begin
      if (lw == 2'h2)
        next_rdata = ext_sync;
      else if (lw == 2'h1)
        next_rdata[sub_lo[1]*16 +: 16] = ext_sync[15:0];
      else
        next_rdata[sub_lo*8 +: 8] = ext_sync[7:0];
    end
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
      rdata <= 32'h0;
    else
      rdata <= next_rdata;
  end

  // ----------------------------------------------------------------------
  // pin decode for the coming cycle
  // ----------------------------------------------------------------------
  logic busy_next; // an access runs in the coming cycle
  logic sel_low; // high bank selects run active low
  logic [3:0] strobe_pat; // active-low lanes of this sub-transfer
  logic strobe_on; // strobes may assert in the coming cycle
  logic bus_style; // alternate bus style
  logic [31:0] wlane; // write data steered to the bank lanes

  assign busy_next = (next_state == smc_pkg::ST_ACCESS);
  assign sel_low = fld[smc_pkg::SMC_F_SEL_LOW];
  assign bus_style = fld[smc_pkg::SMC_F_BUS_STYLE];

  // 32-bit banks decode size and address, narrow banks use low lanes
  assign strobe_pat =
    (lw == 2'h2) ?
      ((size == smc_pkg::SMC_BSIZE_WORD) ? 4'h0 :
       (size == smc_pkg::SMC_BSIZE_HALF) ?
         (addr[1] ? 4'h3 : 4'hc) :
         ~(4'h1 << addr[1:0])) :
    (lw == 2'h1) ?
      ((size == smc_pkg::SMC_BSIZE_BYTE) ?
         (addr[0] ? 4'hd : 4'he) : 4'hc) :
    4'he;

  // flash timing keeps the strobes off in the first cycle of each part
  assign strobe_on = busy_next &&
                     !(fld[smc_pkg::SMC_F_FLASH] &&
                       (sub_done || state != smc_pkg::ST_ACCESS));

  assign wlane = (lw == 2'h2) ? wdata :
                 (lw == 2'h1) ? {16'h0, wdata[sub_lo[1]*16 +: 16]} :
                 {24'h0, wdata[sub_lo*8 +: 8]};

  // ----------------------------------------------------------------------
  // registered external pins
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST || !busy_next)
    begin
      // nothing runs: every select, strobe and enable inactive
      O_BANK_SELECT_LOW <= 6'h3f;
      O_BANK_SELECT_HIGH <= sel_low ? 2'h3 : 2'h0;
      O_BYTE_WRITE_STROBE <= 4'hf;
      O_READ_OUTPUT_ENABLE_N <= 1'b1;
      O_EXT_DATA_OE <= 1'b0;
      O_READ_NOT_WRITE <= 1'b1;
    end
    else
    begin
      O_BANK_SELECT_LOW <= (bank[2:1] == 2'h3) ? 6'h3f :
                           ~(6'h1 << bank);
      O_BANK_SELECT_HIGH <= (bank[2:1] != 2'h3) ? (sel_low ? 2'h3 : 2'h0) :
                            (sel_low ? ~(2'h1 << bank[0]) :
                             (2'h1 << bank[0]));
      O_BYTE_WRITE_STROBE <= (strobe_on && (wr || bus_style)) ?
                             strobe_pat : 4'hf;
      O_READ_OUTPUT_ENABLE_N <= !(strobe_on && !wr && !bus_style);
      O_EXT_DATA_OE <= wr;
      O_READ_NOT_WRITE <= !wr;
    end
  end

  // address, lane sequence and write data follow the current part
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
    begin
      O_EXT_ADDR <= 24'h0;
      O_LANE_SEQUENCE_CTRL <= 2'h0;
      O_EXT_DATA <= 32'h0;
    end
    else
    begin
      O_EXT_ADDR <= {addr[smc_pkg::SMC_ADDR_W-1:2], sub_lo};
      O_LANE_SEQUENCE_CTRL <= sub_lo;
      O_EXT_DATA <= wlane;
    end
  end

  // ----------------------------------------------------------------------
  // bus side answers
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
    begin
      O_BWAIT <= 1'b0;
      O_BD <= 32'h0;
      O_BD_OE <= 1'b0;
    end
    else
    begin
      // the bus stalls for the whole access sequence
      O_BWAIT <= (next_state == smc_pkg::ST_ACCESS);
      if (reg_rd)
      begin
        O_BD <= cfg[reg_idx];
        O_BD_OE <= 1'b1;
      end
      else if (sub_done && last_sub && !wr)
      begin
        O_BD <= next_rdata;
        O_BD_OE <= 1'b1;
      end
      else
      begin
        O_BD_OE <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // expansion clock gating
  // ----------------------------------------------------------------------
  logic gate_en; // enable decided on the rising edge
  logic gate_low; // enable moved to the low phase, glitch free

  // linger bridges the recovery and idle gap so that a transfer taken
  // right after the previous one sees a continuous clock
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
    begin
      linger <= 1'b0;
      gate_en <= 1'b0;
    end
    else
    begin
      linger <= (state != smc_pkg::ST_IDLE);
      gate_en <= fld[smc_pkg::SMC_F_CLK_EN] &&
                 (busy_next || state != smc_pkg::ST_IDLE || linger);
    end
  end

  always_ff @(negedge I_CLK_SYS)
  begin
    gate_low <= gate_en;
  end

  // the bus clock itself is forwarded, gated only in its low phase
  assign O_EXPANSION_CLOCK_OUT = I_CLK_SYS && gate_low;

endmodule : smc_top
`default_nettype wire

// ### testbench/smc_top_monitor.sv
// port checker of the static memory controller, bound to smc_top
`timescale 1ns/100ps
`default_nettype none
module smc_top_monitor (
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic O_BD_OE,
  input wire logic O_BWAIT,
  input wire logic O_EXT_DATA_OE,
  input wire logic [23:0] O_EXT_ADDR,
  input wire logic [5:0] O_BANK_SELECT_LOW,
  input wire logic [3:0] O_BYTE_WRITE_STROBE,
  input wire logic O_READ_OUTPUT_ENABLE_N,
  input wire logic O_READ_NOT_WRITE,
  input wire logic [1:0] O_LANE_SEQUENCE_CTRL
);
  // ----------------------------------------------------------------
  // checks on the bus clock, quiet while reset is high
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_SYS_RST);
  // outside an access the pins must leave the bus alone
  idle_pins_quiet_a: assert property (!O_BWAIT |->
    O_BANK_SELECT_LOW == 6'h3f && O_BYTE_WRITE_STROBE == 4'hf &&
    O_READ_OUTPUT_ENABLE_N) else $error("pins active while idle");
  one_select_a: assert property (O_BWAIT |->
    $onehot0(~O_BANK_SELECT_LOW)) else $error("two selects low");
  oe_on_read_a: assert property (!O_READ_OUTPUT_ENABLE_N |->
    O_BWAIT && O_READ_NOT_WRITE) else $error("enable off a read");
  read_return_a: assert property (
    $fell(O_BWAIT) && !$past(O_READ_OUTPUT_ENABLE_N) |-> O_BD_OE)
    else $error("read ended without data");
  min_access_a: assert property (
    $rose(O_BWAIT) && !O_READ_NOT_WRITE |-> O_BWAIT[*2])
    else $error("access too short");
  // the master relies on one quiet cycle before the next access
  recover_gap_a: assert property ($fell(O_BWAIT) |=> !O_BWAIT)
    else $error("no recovery cycle");
  write_drive_a: assert property (O_EXT_DATA_OE |->
    O_BWAIT && !O_READ_NOT_WRITE) else $error("data driven off a write");
  lane_follow_a: assert property (O_BWAIT |->
    O_LANE_SEQUENCE_CTRL == O_EXT_ADDR[1:0]) else $error("lane mismatch");
  cover property ($fell(O_BWAIT) && O_BD_OE);
  cover property ($rose(O_EXT_DATA_OE));
  cover property (O_BWAIT && O_LANE_SEQUENCE_CTRL == 2'h3);
endmodule : smc_top_monitor
bind smc_top smc_top_monitor smc_top_monitor_inst (.I_CLK_SYS, .I_SYS_RST,
  .O_BD_OE, .O_BWAIT, .O_EXT_DATA_OE, .O_EXT_ADDR, .O_BANK_SELECT_LOW,
  .O_BYTE_WRITE_STROBE, .O_READ_OUTPUT_ENABLE_N, .O_READ_NOT_WRITE,
  .O_LANE_SEQUENCE_CTRL);
`default_nettype wire

// ### testbench/smc_mem_model.sv
// stand-in for the memories and peripherals behind the pins
`timescale 1ns/100ps
`default_nettype none
module smc_mem_model (
  input wire logic i_clk_link,
  input wire logic i_active,
  input wire logic i_oe_n,
  input wire logic [1:0] i_lane,
  input wire logic i_pol,
  input wire logic [3:0] i_stall,
  output logic [31:0] o_data,
  output logic o_ready
);
  logic [3:0] left = 4'h0; // link cycles still to stretch
  logic [31:0] last = 32'h0; // last value put on the data pins
  logic hold; // stretch wish before polarity
  // fixed stretch counted in link clocks, reloaded between accesses
  always @(posedge i_clk_link)
    if (!i_active)
      left <= i_stall;
    else if (left != 4'h0)
      left <= left - 4'h1;
  assign hold = i_active && left != 4'h0;
  assign o_ready = i_pol ? hold : !hold;
  // every lane returns 0x54 plus its low address bits
  always @*
    if (!i_oe_n)
      last = {4{6'h15, i_lane}};
  // released pins show the inverse so stale data never looks fresh
  assign o_data = i_oe_n ? ~last : last;
endmodule : smc_mem_model
`default_nettype wire

// ### testbench/static_memory_controller_test.sv
// self-checking bench of the static memory controller
`timescale 1ns/100ps
`default_nettype none
module static_memory_controller_test;
  // ----------------------------------------------------------------
  // pins and bookkeeping
  // ----------------------------------------------------------------
  logic clk = 1'b0, lclk = 1'b0, rst = 1'b1, msel = 1'b0, rsel = 1'b0;
  logic bwr = 1'b0, pol = 1'b0, rbd_oe, bwait, edo_oe, oe_n, rnw, eclk;
  logic rdy;
  logic [31:0] ba = '0, bd = '0, rbd, edo, edi, rd;
  logic [1:0] btran = 2'h0, bsize = 2'h0, sh, lane, shi;
  logic [3:0] ws, str, stall = 4'h0;
  logic [5:0] sl, slo;
  logic [23:0] eaddr;
  logic [31:0] cfg [4] = '{32'h4, 32'h0, 32'h0, 32'h0}; // shadow copy
  int failures = 0, comparisons = 0, cyc, ecnt, ticks = 0;
  wire logic act = sl != 6'h3f || sh != 2'h0; // a bank is selected
  always #5 clk = ~clk;
  // link clock offset so the two domains drift apart
  initial #3 forever #24 lclk = ~lclk;
  always @(posedge eclk) ecnt++;
  smc_top smc_top_inst (.I_CLK_SYS(clk), .I_SYS_RST(rst),
    .I_CLK_LINK(lclk), .I_MEM_SELECT(msel), .I_CONFIG_REG_SELECT(rsel),
    .I_BA(ba), .I_BTRAN(btran), .I_BSIZE(bsize), .I_BWRITE(bwr),
    .I_BD(bd), .O_BD(rbd), .O_BD_OE(rbd_oe), .O_BWAIT(bwait),
    .I_EXTERNAL_READY_IN(rdy), .I_BOOT_MODE(2'h0), .I_EXT_DATA(edi),
    .O_EXT_DATA(edo), .O_EXT_DATA_OE(edo_oe), .O_EXT_ADDR(eaddr),
    .O_BANK_SELECT_LOW(sl), .O_BANK_SELECT_HIGH(sh),
    .O_BYTE_WRITE_STROBE(ws), .O_READ_OUTPUT_ENABLE_N(oe_n),
    .O_READ_NOT_WRITE(rnw), .O_LANE_SEQUENCE_CTRL(lane),
    .O_EXPANSION_CLOCK_OUT(eclk));
  smc_mem_model smc_mem_model_inst (.i_clk_link(lclk), .i_active(act),
    .i_oe_n(oe_n), .i_lane(eaddr[1:0]), .i_pol(pol), .i_stall(stall),
    .o_data(edi), .o_ready(rdy));
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // one register access; a read leaves its answer in rd
  task automatic reg_io(input int i, input logic w);
    @(negedge clk);
    rsel = 1'b1;
    bwr = w;
    ba = smc_pkg::SMC_REG_BASE + 32'(i * 4);
    bd = cfg[i];
    @(negedge clk);
    rsel = 1'b0;
    bwr = 1'b0;
    rd = rbd_oe ? rbd : 'x;
  endtask : reg_io
  task automatic setb(input int b, input logic [15:0] f);
    cfg[b / 2][16 * (b % 2) +: 16] = f;
    reg_io(b / 2, 1'b1);
  endtask : setb
  // one memory access; gathers what the pins showed while busy
  task automatic acc(input logic [31:0] a, input logic [1:0] s,
    input logic w);
    @(negedge clk);
    msel = 1'b1;
    btran = 2'h2;
    ba = a;
    bsize = s;
    bwr = w;
    @(negedge clk);
    msel = 1'b0;
    btran = 2'h0;
    bwr = 1'b0;
    {cyc, ecnt, str, slo, shi} = {64'h0, 4'hf, 6'h3f, 2'h0};
    while (bwait === 1'b1 && cyc < 300)
    begin
      str &= ws;
      slo &= sl;
      shi |= sh;
      cyc++;
      @(negedge clk);
    end
    rd = rbd_oe ? rbd : 'x;
    @(negedge clk);
  endtask : acc
  task automatic t_regs;
    for (int i = 0; i < 4; i++)
    begin
      reg_io(i, 1'b0);
      chk("reg_reset", i == 0 ? 32'h4 : 32'h0, rd);
      cfg[i] = 32'h2a5a15a5 + 32'(i);
      reg_io(i, 1'b1);
      reg_io(i, 1'b0);
      chk("reg_back", cfg[i], rd);
      cfg[i] = '0;
      reg_io(i, 1'b1);
    end
  endtask : t_regs
  task automatic t_decode;
    for (int b = 0; b < 8; b++)
    begin
      acc(32'(b) << 24, 2'h2, 1'b0);
      chk("sel_low", b < 6 ? ~(32'h1 << b) & 32'h3f : 32'h3f, slo);
      chk("sel_high", b < 6 ? 32'h0 : 32'(b - 5), shi);
    end
  endtask : t_decode
  task automatic t_strobe;
    logic [3:0] e [7] = '{4'h0, 4'h3, 4'hc, 4'h7, 4'hb, 4'hd, 4'he};
    logic [1:0] s [7] = '{2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
    logic [1:0] o [7] = '{2'h0, 2'h2, 2'h0, 2'h3, 2'h2, 2'h1, 2'h0};
    for (int k = 0; k < 7; k++)
    begin
      acc({30'h0, o[k]}, s[k], 1'b1);
      chk("strobe", e[k], str);
    end
    setb(1, 16'h0100);
    acc(32'h01000000, 2'h2, 1'b1);
    chk("half_strobe", 4'hc, str);
    chk("half_cycles", 4, cyc);
  endtask : t_strobe
  task automatic t_wait;
    setb(2, 16'h000f);
    acc(32'h02000000, 2'h2, 1'b0);
    chk("wait16_cycles", 17, cyc);
    chk("word_data", 32'h54545454, rd);
  endtask : t_wait
  // byte bank word read, first plain then with the burst shortcut
  task automatic t_narrow;
    setb(3, 16'h0203);
    acc(32'h03000000, 2'h2, 1'b0);
    chk("byte_cycles", 20, cyc);
    chk("byte_word", 32'h57565554, rd);
    setb(3, 16'h02a3);
    acc(32'h03000000, 2'h2, 1'b0);
    chk("burst_cycles", 14, cyc);
  endtask : t_narrow
  // stretch by the far side in both polarities, clock gating
  task automatic t_ready;
    stall = 4'h3;
    for (int p = 0; p < 2; p++)
    begin
      pol = p[0];
      setb(4, p != 0 ? 16'h2407 : 16'h0407);
      acc(32'h04000000, 2'h2, 1'b0);
      chk("stretch", 1, cyc >= 11 && cyc <= 26);
      chk("clock_on", 1, ecnt != 0);
    end
    pol = 1'b0;
    stall = 4'h0;
    acc(32'h05000000, 2'h2, 1'b0);
    chk("clock_off", 0, ecnt);
  endtask : t_ready
  always @(posedge clk)
  begin
    ticks++;
    if (ticks == 5000)
    begin
      failures++;
      summarize;
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_regs;
    t_decode;
    t_strobe;
    t_wait;
    t_narrow;
    t_ready;
    summarize;
  end
endmodule : static_memory_controller_test
`default_nettype wire
